// file: verilog/dual_modulator.sv
// Dual-output 12-bit modulator: prescaler, 8-bit fundamental counter,
// 4-bit extra-pulse counter, two outputs with match buffers, interrupt.
// Assumes a byte register port with one-cycle reads and an oscillator
// clock pin that is asynchronous to mclk and much slower than it.
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module dual_modulator
  import dual_modulator_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Oscillator clock pin, sampled as data
  input wire logic oscillator_clock,
  // Modulator outputs and interrupt
  output logic output_a,
  output logic output_b,
  output logic irq
);

  // Register state
  logic [3:0] extra_q [2];
  logic [7:0] width_q [2];
  ctrl_s ctrl_q;
  logic [7:0] prescale_q;
  logic [7:0] clk_sel_q;
  logic [NUM_EVENTS-1:0] int_status_q;
  logic [NUM_EVENTS-1:0] int_mask_q;
  logic [DATA_W-1:0] rdata_q;

  // Counting state
  logic [2:0] osc_sync_q;
  logic osc_level_q;
  logic [7:0] pre_cnt_q;
  logic [7:0] fund_cnt_q;
  logic [3:0] extra_cnt_q;
  logic [7:0] buf_q [2];
  logic [1:0] stretch_q;
  logic [1:0] out_q;
  logic irq_q;

  // Decoded strobes and events
  logic wr_ctrl;
  logic rd_status;
  logic running;
  logic [1:0] out_run;
  logic osc_rise;
  logic count_clk;
  logic pre_match;
  logic [7:0] fund_top;
  logic fund_match;
  logic overall_end;
  logic [NUM_EVENTS-1:0] events;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign rd_status = reg_rd && (reg_addr == OFS_INT_STATUS);
  assign out_run = {ctrl_q.output_b_run, ctrl_q.output_a_run};
  assign running = |out_run;

  // Oscillator pin: three flops, a level counts once stages two and three agree
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= {osc_sync_q[1:0], oscillator_clock};
    end
  end

  // Accepted oscillator level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc_level_q <= 1'b0;
    end else if (osc_sync_q[1] == osc_sync_q[2]) begin
      osc_level_q <= osc_sync_q[2];
    end
  end

  assign osc_rise = (osc_sync_q[1] == osc_sync_q[2]) && osc_sync_q[2] && !osc_level_q;
  // Count clock: system clock when select is 0, oscillator edges when 1
  assign count_clk = clk_sel_q[CLK_SEL_BIT] ? osc_rise : 1'b1;

  // Prescaler: value plus one count clocks per tick
  assign pre_match = count_clk && (pre_cnt_q == prescale_q);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_q <= 8'h00;
    end else if (!running || pre_match) begin
      pre_cnt_q <= 8'h00;
    end else if (count_clk) begin
      pre_cnt_q <= pre_cnt_q + 8'h01;
    end
  end

  // Last count of the fundamental period: (field + 1) * 16 ticks in total
  assign fund_top = {ctrl_q.period_field, FUND_BLOCK_LAST};
  assign fund_match = pre_match && (fund_cnt_q == fund_top);
  assign overall_end = fund_match && (extra_cnt_q == EXTRA_LAST);

  // Fundamental counter, shared by both outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fund_cnt_q <= 8'h00;
    end else if (!running || fund_match) begin
      fund_cnt_q <= 8'h00;
    end else if (pre_match) begin
      fund_cnt_q <= fund_cnt_q + 8'h01;
    end
  end

  // Extra-pulse counter: only a module reset clears it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extra_cnt_q <= 4'h0;
    end else if (fund_match) begin
      extra_cnt_q <= extra_cnt_q + 4'h1;
    end
  end

  // Per-output buffer, stretch choice and output pin
  for (genvar i = 0; i < 2; i++) begin : g_out
    logic [3:0] next_extra;
    logic extra_hit;
    assign next_extra = extra_cnt_q + 4'h1;
    // Cycles numbered below the value stretch; the equality marks the last one
    assign extra_hit = (next_extra == extra_q[i]);

    // Match buffer updates only while its output is stopped or at the period start, so a write never glitches a pulse
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        buf_q[i] <= RST_WIDTH;
      end else if (!out_run[i] || fund_match) begin
        buf_q[i] <= width_q[i];
      end
    end

    // Stretch flag: on for extra counts 0..value-1, off from the match on
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        stretch_q[i] <= 1'b0;
      end else if (!out_run[i]) begin
        stretch_q[i] <= (extra_q[i] > extra_cnt_q);
      end else if (fund_match) begin
        if (next_extra == 4'h0) begin
          stretch_q[i] <= (extra_q[i] != 4'h0);
        end else if (extra_hit) begin
          stretch_q[i] <= 1'b0;
        end
      end
    end

    // High until the counter meets the buffer, one tick more when stretched
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        out_q[i] <= 1'b0;
      end else if (!out_run[i]) begin
        out_q[i] <= 1'b0;
      end else begin
        out_q[i] <= (fund_cnt_q < buf_q[i]) || ((fund_cnt_q == buf_q[i]) && stretch_q[i]);
      end
    end
  end

  // Register writes for the plain data registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extra_q[0] <= RST_EXTRA[7:EXTRA_LSB];
      extra_q[1] <= RST_EXTRA[7:EXTRA_LSB];
      width_q[0] <= RST_WIDTH;
      width_q[1] <= RST_WIDTH;
      prescale_q <= RST_PRESCALE;
      clk_sel_q <= RST_CLK_SEL;
      int_mask_q <= RST_INT;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_A_EXTRA: extra_q[0] <= reg_wdata[7:EXTRA_LSB];
        OFS_B_EXTRA: extra_q[1] <= reg_wdata[7:EXTRA_LSB];
        OFS_A_WIDTH: width_q[0] <= reg_wdata;
        OFS_B_WIDTH: width_q[1] <= reg_wdata;
        OFS_PRESCALE: prescale_q <= reg_wdata;
        // Software should change the select only while stopped
        OFS_CLK_SEL: clk_sel_q <= reg_wdata & ~(8'h01 << CLK_GAP_BIT);
        OFS_INT_MASK: int_mask_q <= reg_wdata[NUM_EVENTS-1:0];
        default: ;
      endcase
    end
  end

  // Control register; overflow sets over a clearing write in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= ctrl_s'(RST_CTRL);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_s'(reg_wdata);
        ctrl_q.period_overflow_flag <= overall_end || (ctrl_q.period_overflow_flag && reg_wdata[1]);
      end else if (overall_end) begin
        ctrl_q.period_overflow_flag <= 1'b1;
      end
    end
  end

  // Sticky event bits, cleared by a read; a new event beats the clear
  assign events[INT_OVERALL_BIT] = overall_end && ctrl_q.interrupt_request_enable;
  assign events[INT_FUND_BIT] = fund_match;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_status_q <= RST_INT;
    end else if (rd_status) begin
      int_status_q <= events;
    end else begin
      int_status_q <= int_status_q | events;
    end
  end

  // Interrupt level: flag with enable, or any unmasked sticky event
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ctrl_q.period_overflow_flag && ctrl_q.interrupt_request_enable) ||
               (|(int_status_q & int_mask_q));
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads as zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_A_EXTRA: rdata_q <= {extra_q[0], 4'h0};
        OFS_B_EXTRA: rdata_q <= {extra_q[1], 4'h0};
        OFS_A_WIDTH: rdata_q <= width_q[0];
        OFS_B_WIDTH: rdata_q <= width_q[1];
        OFS_CTRL: rdata_q <= ctrl_q;
        OFS_PRESCALE: rdata_q <= prescale_q;
        OFS_CLK_SEL: rdata_q <= clk_sel_q;
        OFS_INT_STATUS: rdata_q <= {6'h00, int_status_q};
        OFS_INT_MASK: rdata_q <= {6'h00, int_mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign output_a = out_q[0];
  assign output_b = out_q[1];
  assign irq = irq_q;

endmodule : dual_modulator

// file: verilog/dual_modulator_pkg.sv
// Package for the dual-output 12-bit modulator: register map, field layout,
// reset values and the control register struct.
// Assumes a byte-wide register port with 16-bit addresses.
package dual_modulator_pkg;

  // Register bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register byte addresses
  localparam logic [15:0] OFS_A_EXTRA = 16'h7FAA;
  localparam logic [15:0] OFS_A_WIDTH = 16'h7FAB;
  localparam logic [15:0] OFS_B_EXTRA = 16'h7FAC;
  localparam logic [15:0] OFS_B_WIDTH = 16'h7FAD;
  localparam logic [15:0] OFS_CTRL = 16'h7FAE;
  localparam logic [15:0] OFS_PRESCALE = 16'h7FAF;
  localparam logic [15:0] OFS_CLK_SEL = 16'h7FB6;
  localparam logic [15:0] OFS_INT_STATUS = 16'h7FB8;
  localparam logic [15:0] OFS_INT_MASK = 16'h7FB9;

  // Reset values
  localparam logic [7:0] RST_EXTRA = 8'h00;
  localparam logic [7:0] RST_WIDTH = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic [1:0] RST_INT = 2'h0;

  // Field positions
  localparam int EXTRA_LSB = 4;      // Extra-pulse value sits in bits 7..4
  localparam int CLK_SEL_BIT = 0;    // Count clock select
  localparam int CLK_GAP_BIT = 1;    // Bit that does not exist, reads 0
  localparam int INT_OVERALL_BIT = 0; // Event: overall period ended
  localparam int INT_FUND_BIT = 1;    // Event: fundamental period ended
  localparam int NUM_EVENTS = 2;

  // Fundamental period is (period_field + 1) blocks of 16 ticks; this is the last tick of a block
  localparam logic [3:0] FUND_BLOCK_LAST = 4'hF;
  localparam logic [3:0] EXTRA_LAST = 4'hF;

  // Control register layout, MSB first
  typedef struct packed {
    logic [3:0] period_field;
    logic output_b_run;
    logic output_a_run;
    logic period_overflow_flag;
    logic interrupt_request_enable;
  } ctrl_s;

endpackage : dual_modulator_pkg

// file: verification/dual_modulator_properties.sv
// Checker for the dual modulator: register port and output relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module dual_modulator_properties
  import dual_modulator_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Outputs
  input wire logic output_a,
  input wire logic output_b,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Read data of the given address stand in this cycle
  sequence read_of(logic [15:0] a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence
  // Control write clearing one run bit; the output register lags one cycle
  sequence stop_of(int b);
    reg_wr && reg_addr == OFS_CTRL && !reg_wdata[b];
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not zero");
  a_extra_low_a: assert property (read_of(OFS_A_EXTRA) |-> reg_rdata[3:0] == 4'h0) else $error("a extra low");
  b_extra_low_a: assert property (read_of(OFS_B_EXTRA) |-> reg_rdata[3:0] == 4'h0) else $error("b extra low");
  clk_gap_a: assert property (read_of(OFS_CLK_SEL) |-> !reg_rdata[CLK_GAP_BIT]) else $error("clock select bit1");
  a_stop_low_a: assert property (stop_of(2) |-> ##2 !output_a) else $error("a not low");
  b_stop_low_a: assert property (stop_of(3) |-> ##2 !output_b) else $error("b not low");
  a_stop_hold_a: assert property (stop_of(2) ##1 (!reg_wr) [*4] |-> !output_a && $stable(output_a))
    else $error("a moved while stopped");
  ov_irq_a: assert property (read_of(OFS_CTRL) ##0 reg_rdata[1:0] == 2'b11 |-> irq) else $error("irq missing");
endmodule : dual_modulator_properties

bind dual_modulator dual_modulator_properties chk_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_a(output_a),
  .output_b(output_b), .irq(irq));

// file: verification/dual_modulator_bench.sv
// Self-checking bench for the dual modulator: register tasks and duty counts.
// Assumes a slow oscillator pin made here, one rising edge every eight clocks.
`timescale 1ns/100ps
module dual_modulator_bench;
  import dual_modulator_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic output_a, output_b, irq;
  logic osc = 1'b0;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, t1;
  // Every mapped register plus one unmapped hole, all zero after reset
  logic [15:0] map_q [10] = '{OFS_A_EXTRA, OFS_A_WIDTH, OFS_B_EXTRA, OFS_B_WIDTH, OFS_CTRL, OFS_PRESCALE,
    OFS_CLK_SEL, OFS_INT_STATUS, OFS_INT_MASK, 16'h7FB0};
  dual_modulator dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oscillator_clock(osc), .output_a(output_a), .output_b(output_b),
    .irq(irq));
  // Clock, cycle count and reset
  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // Oscillator pin well below a quarter of mclk, so the three-flop sampler sees every edge
  always @(posedge mclk) if (cyc % 4 == 3) osc <= ~osc;
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
  end
  // Watchdog well beyond the eight thousand or so cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    final_report();
  end
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(what, 16'(reg_rdata), 16'(exp));
  endtask : rd
  // Settle long enough for a prescaler wrap, then count high cycles over 256 clocks
  task pwm(input logic [7:0] c, p, wa, wb, ea, eb, input int xa, xb);
    int na;
    int nb;
    na = 0;
    nb = 0;
    wr(OFS_PRESCALE, p);
    wr(OFS_A_WIDTH, wa);
    wr(OFS_B_WIDTH, wb);
    wr(OFS_A_EXTRA, ea);
    wr(OFS_B_EXTRA, eb);
    wr(OFS_CTRL, c);
    repeat (800) @(posedge mclk);
    repeat (256) begin
      @(posedge mclk);
      #1 na += int'(output_a === 1'b1);
      nb += int'(output_b === 1'b1);
    end
    chk("high cycles a", 16'(na), 16'(xa));
    chk("high cycles b", 16'(nb), 16'(xb));
    $display("pwm case %0h done", c);
  endtask : pwm
  // Bounded wait for the interrupt level, returning the cycle seen
  task wirq(output int t);
    for (int k = 0; k < 1000 && irq !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    t = cyc;
  endtask : wirq
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(posedge mclk);
    foreach (map_q[i]) rd(map_q[i], 8'h00, "reset value");
    wr(OFS_A_EXTRA, 8'hFF);
    rd(OFS_A_EXTRA, 8'hF0, "a extra");
    wr(OFS_B_EXTRA, 8'h9F);
    rd(OFS_B_EXTRA, 8'h90, "b extra");
    wr(OFS_CLK_SEL, 8'hFF);
    rd(OFS_CLK_SEL, 8'hFD, "clock select");
    wr(OFS_CLK_SEL, 8'h00);
    wr(OFS_A_WIDTH, 8'hA5);
    rd(OFS_A_WIDTH, 8'hA5, "a width");
    $display("register test done");
    pwm(8'h0C, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 32, 80);
    pwm(8'h1C, 8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 16, 24);
    pwm(8'hFC, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 0, 255);
    pwm(8'h0C, 8'h00, 8'h02, 8'h00, 8'h30, 8'hF0, 35, 15);
    pwm(8'h04, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 64, 0);
    pwm(8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 0, 0);
    // Oscillator as count clock: ticks eight clocks apart, select changed only while stopped
    wr(OFS_CLK_SEL, 8'h01);
    pwm(8'h0C, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 32, 80);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CLK_SEL, 8'h00);
    // Overflow with enable: one request per 256 clocks, cleared by a write
    wr(OFS_CTRL, 8'h0D);
    wirq(t0);
    rd(OFS_CTRL, 8'h0F, "ctrl overflow");
    wr(OFS_CTRL, 8'h0D);
    repeat (3) @(posedge mclk);
    #1 chk("irq cleared", 16'(irq), 16'h0000);
    wirq(t1);
    chk("overall period", 16'(t1 - t0), 16'h0100);
    // Fundamental event through the mask, then masked off
    wr(OFS_CTRL, 8'h0C);
    wr(OFS_INT_MASK, 8'h02);
    repeat (20) @(posedge mclk);
    #1 chk("irq masked event", 16'(irq), 16'h0001);
    rd(OFS_INT_MASK, 8'h02, "mask");
    rd(OFS_INT_STATUS, 8'h03, "status");
    wr(OFS_INT_MASK, 8'h00);
    repeat (3) @(posedge mclk);
    #1 chk("irq masked off", 16'(irq), 16'h0000);
    $display("interrupt test done");
    final_report();
  end
endmodule : dual_modulator_bench
